// *** pcim_evt_det.sv ***
// Purpose: edge and level event detector for one sampled pin
// Assumes: sample is already in the clk domain
// Notes:   reserved type codes never report an event
`timescale 1ns/10ps
module pcim_evt_det (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sample,
  input  wire logic [2:0] trig_type,
  output logic            event_hit
);
  import pcim_pkg::*;

  typedef struct packed {
    logic prev;
  } pcim_det_type;

  pcim_det_type det_reg;
  pcim_det_type det_next;

  always_comb begin
    det_next      = det_reg;
    det_next.prev = sample;
    // edges compare current and previous sample, levels use current
    case (trig_type)
      PCIM_EVT_RISE: event_hit = sample & ~det_reg.prev;
      PCIM_EVT_FALL: event_hit = ~sample & det_reg.prev;
      PCIM_EVT_BOTH: event_hit = sample ^ det_reg.prev;
      PCIM_EVT_HIGH: event_hit = sample;
      PCIM_EVT_LOW:  event_hit = ~sample;
      default:       event_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      det_reg <= '0;
    end else begin
      det_reg <= det_next;
    end
  end

endmodule

// *** pcim_pad_model.sv ***
// Purpose: external pad model for the two controlled pins
// Assumes: pads are pure wires, the outside source is weak
// Notes:   the bench drives ext_level in place of the board
`timescale 1ns/10ps
module pcim_pad_model (
  input  wire logic [1:0] ext_level,
  input  wire logic [1:0] pad_out,
  input  wire logic [1:0] pad_oe_n,
  output logic      [1:0] pad_in
);
  // ==========================================================================
  // pad resolution
  // the chip's driver beats the weak outside source
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pad_in[i] = pad_oe_n[i] ? ext_level[i] : pad_out[i];
    end
  end
endmodule

// *** pcim_pin_ctl.sv ***
// Purpose: control, pad settings and event interrupts for two pins
// Assumes: classic wishbone slave, one clock, pads asynchronous
// Notes:   index 0 is pin 23, index 1 is pin 24
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
module pcim_pin_ctl (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [3:0]      wb_sel_i,
  input  wire logic [31:0]     wb_dat_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic [1:0]      pad_in,
  output logic      [1:0]      pad_out,
  output logic      [1:0]      pad_oe_n,
  input  wire logic [1:0]      alt_func_out,
  output logic      [1:0]      pin_in_level,
  output logic      [1:0][2:0] drive_strength_level,
  output logic      [1:0]      strong_pullup_enable,
  output logic      [1:0]      weak_pulldown_enable,
  output logic      [1:0]      medium_pullup_enable,
  output logic      [1:0]      input_path_enable,
  output logic      [1:0]      output_driver_enable,
  output logic      [1:0]      hysteresis_enable,
  output logic                 low_rate_adc_channel_a,
  output logic                 low_rate_adc_channel_b,
  output logic      [1:0][3:0] function_route_select,
  output logic      [1:0]      system_interrupt_controller,
  output logic                 irq
);
  import pcim_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0][31:0] ctl;
    logic [1:0]       pend;
    logic [1:0]       irq_mask;
    logic [1:0]       dout;
    logic [1:0]       pad_out;
    logic [1:0]       pad_oe_n;
    logic             ack;
    logic [31:0]      rdat;
  } pcim_state_type;

  pcim_state_type st_reg;
  pcim_state_type st_next;

  logic [1:0] pin_sync;
  logic [1:0] pin_gated;
  logic [1:0] evt_hit;
  logic       req_new;
  logic       commit;
  logic [1:0] w1c;
  logic [31:0] merged;

  // ==========================================================================
  // helpers
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = m;
  endfunction

  // ==========================================================================
  // pad input sampling and event detection
  pcim_sync2 u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pad_in),
    .q   (pin_sync)
  );

  // disabled input path reads low; its events still hit but the IEN term keeps them from pending
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_gated[i] = pin_sync[i] & st_reg.ctl[i][PCIM_B_IEN];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_det
      pcim_evt_det u_det (
        .clk       (clk),
        .rst       (rst),
        .sample    (pin_gated[g]),
        .trig_type (st_reg.ctl[g][PCIM_B_EVT_HI:PCIM_B_EVT_LO]),
        .event_hit (evt_hit[g])
      );
    end
  endgenerate

  // ==========================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    req_new = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    // writes land at the edge where the master sees ack
    commit  = wb_cyc_i & wb_stb_i & st_reg.ack & wb_we_i;
    w1c     = 2'h0;
    merged  = 32'h0000_0000;
    st_next.ack  = req_new;
    st_next.rdat = 32'h0000_0000;

    if (req_new) begin
      if (hit(wb_adr_i, PCIM_OFS_PIN23_CTL)) begin
        st_next.rdat = st_reg.ctl[0] & PCIM_CTL_WMASK;
      end else if (hit(wb_adr_i, PCIM_OFS_PIN24_CTL)) begin
        st_next.rdat = st_reg.ctl[1] & PCIM_CTL_WMASK;
      end else if (hit(wb_adr_i, PCIM_OFS_IRQ_STAT)) begin
        st_next.rdat = {30'h0, st_reg.pend};
      end else if (hit(wb_adr_i, PCIM_OFS_IRQ_MASK)) begin
        st_next.rdat = {30'h0, st_reg.irq_mask};
      end else if (hit(wb_adr_i, PCIM_OFS_DOUT)) begin
        st_next.rdat = {30'h0, st_reg.dout};
      end else if (hit(wb_adr_i, PCIM_OFS_DIN)) begin
        st_next.rdat = {30'h0, pin_gated};
      end
    end

    if (commit) begin
      if (hit(wb_adr_i, PCIM_OFS_PIN23_CTL)) begin
        merged = merge(st_reg.ctl[0], wb_dat_i, wb_sel_i);
        st_next.ctl[0] = merged & PCIM_CTL_WMASK;
      end else if (hit(wb_adr_i, PCIM_OFS_PIN24_CTL)) begin
        merged = merge(st_reg.ctl[1], wb_dat_i, wb_sel_i);
        st_next.ctl[1] = merged & PCIM_CTL_WMASK;
      end else if (hit(wb_adr_i, PCIM_OFS_IRQ_STAT)) begin
        w1c = wb_sel_i[0] ? wb_dat_i[1:0] : 2'h0;
      end else if (hit(wb_adr_i, PCIM_OFS_IRQ_MASK)) begin
        if (wb_sel_i[0]) begin
          st_next.irq_mask = wb_dat_i[1:0];
        end
      end else if (hit(wb_adr_i, PCIM_OFS_DOUT)) begin
        if (wb_sel_i[0]) begin
          st_next.dout = wb_dat_i[1:0];
        end
      end
    end

    for (int i = 0; i < 2; i++) begin
      // a new event beats a same-cycle clear
      st_next.pend[i] = (st_reg.pend[i] & ~w1c[i]) |
                        (evt_hit[i] & st_reg.ctl[i][PCIM_B_PEND_EN] &
                         st_reg.ctl[i][PCIM_B_IEN]);
      // reserved route codes leave the pad undriven
      st_next.pad_out[i] =
        (st_reg.ctl[i][PCIM_B_ROUTE_HI:PCIM_B_ROUTE_LO] == PCIM_ROUTE_GPIO) ?
        st_reg.dout[i] : alt_func_out[i];
      st_next.pad_oe_n[i] = ~(st_reg.ctl[i][PCIM_B_OEN] &
                              ~st_reg.ctl[i][PCIM_B_ADC] &
                              (st_reg.ctl[i][PCIM_B_ROUTE_HI:PCIM_B_ROUTE_LO]
                               <= PCIM_ROUTE_MAX));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.ctl[0]   <= PCIM_CTL_RESET;
      st_reg.ctl[1]   <= PCIM_CTL_RESET;
      st_reg.dout     <= PCIM_DOUT_RESET;
      st_reg.pad_oe_n <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // outputs
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdat;
  assign pad_out  = st_reg.pad_out;
  assign pad_oe_n = st_reg.pad_oe_n;
  assign pin_in_level = pin_gated;
  assign irq = |(st_reg.pend & st_reg.irq_mask);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      drive_strength_level[i]  = st_reg.ctl[i][PCIM_B_DRV_HI:PCIM_B_DRV_LO];
      strong_pullup_enable[i]  = st_reg.ctl[i][PCIM_B_SPU];
      weak_pulldown_enable[i]  = st_reg.ctl[i][PCIM_B_WPD];
      medium_pullup_enable[i]  = st_reg.ctl[i][PCIM_B_MPU];
      input_path_enable[i]     = st_reg.ctl[i][PCIM_B_IEN];
      output_driver_enable[i]  = st_reg.ctl[i][PCIM_B_OEN];
      hysteresis_enable[i]     = st_reg.ctl[i][PCIM_B_HYS];
      function_route_select[i] = st_reg.ctl[i][PCIM_B_ROUTE_HI:PCIM_B_ROUTE_LO];
      // request only while enabled, pending and forwarded
      system_interrupt_controller[i] = st_reg.pend[i] &
                                       st_reg.ctl[i][PCIM_B_PEND_EN] &
                                       st_reg.ctl[i][PCIM_B_FWD_MASK];
    end
    // exclusive channel use is left to software
    low_rate_adc_channel_a = st_reg.ctl[0][PCIM_B_ADC];
    low_rate_adc_channel_b = st_reg.ctl[1][PCIM_B_ADC];
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FWD_MASK_BLOCKS: assert property (
    !st_reg.ctl[0][PCIM_B_FWD_MASK] |-> !system_interrupt_controller[0])
    else $error("request forwarded while mask bit is low");

  AST_FWD_REQ_FOLLOWS: assert property (
    (st_reg.pend[1] && st_reg.ctl[1][PCIM_B_PEND_EN] && st_reg.ctl[1][PCIM_B_FWD_MASK])
    |-> system_interrupt_controller[1])
    else $error("pending forwarded event not requested");

  AST_FALL_SETS_PEND: assert property (
    (st_reg.ctl[0][PCIM_B_PEND_EN] && st_reg.ctl[0][PCIM_B_IEN] &&
     st_reg.ctl[0][PCIM_B_EVT_HI:PCIM_B_EVT_LO] == PCIM_EVT_FALL && $fell(pin_in_level[0]))
    |=> st_reg.pend[0])
    else $error("falling edge did not set pending");

  AST_NO_PEND_DISABLED: assert property (
    $rose(st_reg.pend[0]) |-> $past(st_reg.ctl[0][PCIM_B_PEND_EN]))
    else $error("pending set while event enable low");

  AST_LEVEL_HIGH_SETS: assert property (
    (st_reg.ctl[1][PCIM_B_PEND_EN] && st_reg.ctl[1][PCIM_B_IEN] &&
     st_reg.ctl[1][PCIM_B_EVT_HI:PCIM_B_EVT_LO] == PCIM_EVT_HIGH && pin_in_level[1])
    |=> st_reg.pend[1])
    else $error("high level did not set pending");

  AST_INPUT_GATED: assert property (
    !input_path_enable[0] |-> !pin_in_level[0])
    else $error("input seen while input path disabled");

  AST_OE_NEEDS_EN: assert property (
    !st_reg.ctl[1][PCIM_B_OEN] |=> pad_oe_n[1])
    else $error("pad driven while output disabled");

  AST_ANALOG_NO_DRIVE: assert property (
    st_reg.ctl[0][PCIM_B_ADC] |=> pad_oe_n[0])
    else $error("pad driven while analog selected");

  AST_HYS_WRITE: assert property (
    (commit && hit(wb_adr_i, PCIM_OFS_PIN23_CTL) && wb_sel_i[0])
    |=> hysteresis_enable[0] == $past(wb_dat_i[PCIM_B_HYS]))
    else $error("hysteresis bit not taken from write");

  AST_RSVD_READ_ZERO: assert property (
    (commit && hit(wb_adr_i, PCIM_OFS_PIN24_CTL) && wb_sel_i == 4'hf &&
     wb_dat_i == 32'hffff_ffff) |=> st_reg.ctl[1] == PCIM_CTL_WMASK)
    else $error("reserved bits stored on write");

  AST_GPIO_ROUTE: assert property (
    (function_route_select[0] == PCIM_ROUTE_GPIO && $stable(st_reg.dout[0]))
    |=> pad_out[0] == $past(st_reg.dout[0]))
    else $error("gpio route does not drive data register");

  AST_ACK_ONE_CYCLE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  AST_RSVD_TYPE_QUIET: assert property (
    (st_reg.ctl[0][PCIM_B_EVT_HI:PCIM_B_EVT_LO] > PCIM_EVT_LOW) |-> !evt_hit[0])
    else $error("reserved event type raised an event");

  AST_RISE_SETS_PEND: assert property (
    (st_reg.ctl[1][PCIM_B_PEND_EN] && st_reg.ctl[1][PCIM_B_IEN] &&
     st_reg.ctl[1][PCIM_B_EVT_HI:PCIM_B_EVT_LO] == PCIM_EVT_RISE && $rose(pin_in_level[1]))
    |=> st_reg.pend[1])
    else $error("rising edge did not set pending");

  AST_REQ_NEEDS_EN: assert property (
    !st_reg.ctl[1][PCIM_B_PEND_EN] |-> !system_interrupt_controller[1])
    else $error("request raised while event enable low");

  // pending only drops through a write of one to its status bit
  AST_PEND_STICKY: assert property (
    (st_reg.pend[0] &&
     !(commit && hit(wb_adr_i, PCIM_OFS_IRQ_STAT) && wb_sel_i[0] && wb_dat_i[0]))
    |=> st_reg.pend[0])
    else $error("pending dropped without a clear");

  AST_CLEAR_WORKS: assert property (
    (commit && hit(wb_adr_i, PCIM_OFS_IRQ_STAT) && wb_sel_i[0] && wb_dat_i[1] &&
     !evt_hit[1]) |=> !st_reg.pend[1])
    else $error("pending not cleared by write of one");

  AST_DRV_WRITE: assert property (
    (commit && hit(wb_adr_i, PCIM_OFS_PIN24_CTL) && wb_sel_i[1])
    |=> drive_strength_level[1] == $past(wb_dat_i[PCIM_B_DRV_HI:PCIM_B_DRV_LO]))
    else $error("drive level not taken from write");

  AST_PULL_WRITE: assert property (
    (commit && hit(wb_adr_i, PCIM_OFS_PIN23_CTL) && wb_sel_i[1])
    |=> strong_pullup_enable[0] == $past(wb_dat_i[PCIM_B_SPU]) &&
        weak_pulldown_enable[0] == $past(wb_dat_i[PCIM_B_WPD]) &&
        medium_pullup_enable[0] == $past(wb_dat_i[PCIM_B_MPU]))
    else $error("pull enables not taken from write");

  AST_RSVD_ZERO: assert property (
    ((st_reg.ctl[0] | st_reg.ctl[1]) & ~PCIM_CTL_WMASK) == 32'h0000_0000)
    else $error("reserved control bit holds a one");

  AST_IRQ_MASKED: assert property (
    st_reg.irq_mask == 2'h0 |-> !irq)
    else $error("irq raised with all status bits masked");

  // read data stays zero outside the answer cycle
  AST_RDAT_IDLE: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data seen outside ack");

  AST_ACK_ANSWERS: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  AST_RSVD_ROUTE_OFF: assert property (
    st_reg.ctl[1][PCIM_B_ROUTE_HI:PCIM_B_ROUTE_LO] > PCIM_ROUTE_MAX |=> pad_oe_n[1])
    else $error("pad driven on reserved route code");

  AST_OE_DRIVES: assert property (
    (st_reg.ctl[0][PCIM_B_OEN] && !st_reg.ctl[0][PCIM_B_ADC] &&
     st_reg.ctl[0][PCIM_B_ROUTE_HI:PCIM_B_ROUTE_LO] == PCIM_ROUTE_GPIO) |=> !pad_oe_n[0])
    else $error("pad not driven while output enabled");

endmodule

// *** pcim_pkg.sv ***
// Purpose: shared constants for the two-pin control and event block
// Assumes: 32-bit classic wishbone, byte addresses on an 8-bit port
// Notes:   one control word per pin, plus status, mask and data words
package pcim_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] PCIM_OFS_PIN23_CTL = 8'h68;
  localparam logic [7:0] PCIM_OFS_PIN24_CTL = 8'h6c;
  localparam logic [7:0] PCIM_OFS_IRQ_STAT  = 8'h80;
  localparam logic [7:0] PCIM_OFS_IRQ_MASK  = 8'h84;
  localparam logic [7:0] PCIM_OFS_DOUT      = 8'h88;
  localparam logic [7:0] PCIM_OFS_DIN       = 8'h8c;

  // ==========================================================================
  // control word layout
  localparam int PCIM_B_FWD_MASK = 25;
  localparam int PCIM_B_EVT_HI   = 23;
  localparam int PCIM_B_EVT_LO   = 21;
  localparam int PCIM_B_PEND_EN  = 20;
  localparam int PCIM_B_DRV_HI   = 14;
  localparam int PCIM_B_DRV_LO   = 12;
  localparam int PCIM_B_SPU      = 11;
  localparam int PCIM_B_WPD      = 9;
  localparam int PCIM_B_MPU      = 8;
  localparam int PCIM_B_IEN      = 7;
  localparam int PCIM_B_OEN      = 6;
  localparam int PCIM_B_HYS      = 5;
  localparam int PCIM_B_ADC      = 4;
  localparam int PCIM_B_ROUTE_HI = 3;
  localparam int PCIM_B_ROUTE_LO = 0;

  localparam logic [31:0] PCIM_CTL_WMASK = 32'h02f0_7bff;
  localparam logic [31:0] PCIM_CTL_RESET = 32'h0000_1001;
  localparam logic [1:0]  PCIM_DOUT_RESET = 2'h0;

  localparam logic [3:0] PCIM_ROUTE_GPIO = 4'h1;
  localparam logic [3:0] PCIM_ROUTE_MAX  = 4'h8;

  // ==========================================================================
  // event type codes
  localparam logic [2:0] PCIM_EVT_RISE = 3'h0;
  localparam logic [2:0] PCIM_EVT_FALL = 3'h1;
  localparam logic [2:0] PCIM_EVT_BOTH = 3'h2;
  localparam logic [2:0] PCIM_EVT_HIGH = 3'h3;
  localparam logic [2:0] PCIM_EVT_LOW  = 3'h4;

endpackage

// *** pcim_sync2.sv ***
// Purpose: two-flop synchroniser for the two pad inputs
// Assumes: pads are asynchronous to clk
// Notes:   only the second stage is read outside
`timescale 1ns/10ps
module pcim_sync2 (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] d,
  output logic      [1:0] q
);
  import pcim_pkg::*;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
  } pcim_sync_type;

  pcim_sync_type sync_reg;
  pcim_sync_type sync_next;

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.s2;

endmodule

// *** pin_control_interrupt_mux_tb.sv ***
// Purpose: self-checking bench for the two-pin control and event block
// Assumes: classic wishbone master, one clock, fixed seed
// Notes:   analog select stays off on pin 23 in random writes
`timescale 1ns/10ps
module pin_control_interrupt_mux_tb;
  import pcim_pkg::*;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            wb_cyc_i = 1'b0;
  logic            wb_stb_i = 1'b0;
  logic            wb_we_i = 1'b0;
  logic [7:0]      wb_adr_i = 8'h00;
  logic [3:0]      wb_sel_i = 4'h0;
  logic [31:0]     wb_dat_i = 32'h0;
  logic [31:0]     wb_dat_o, q, d;
  logic            wb_ack_o, irq, low_rate_adc_channel_a, low_rate_adc_channel_b;
  logic [1:0]      pad_in, pad_out, pad_oe_n, pin_in_level, system_interrupt_controller;
  logic [1:0]      alt_func_out = 2'h0;
  logic [1:0]      ext_level = 2'h0;
  logic [1:0]      strong_pullup_enable, weak_pulldown_enable, medium_pullup_enable;
  logic [1:0]      input_path_enable, output_driver_enable, hysteresis_enable;
  logic [1:0][2:0] drive_strength_level;
  logic [1:0][3:0] function_route_select;
  logic [31:0]     shadow [2];
  int              errors = 0;
  int              n_tests = 0;

  always #5 clk = ~clk;

  pcim_pin_ctl i_pcim_pin_ctl (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .alt_func_out(alt_func_out),
    .pin_in_level(pin_in_level), .drive_strength_level(drive_strength_level),
    .strong_pullup_enable(strong_pullup_enable), .weak_pulldown_enable(weak_pulldown_enable),
    .medium_pullup_enable(medium_pullup_enable), .input_path_enable(input_path_enable),
    .output_driver_enable(output_driver_enable), .hysteresis_enable(hysteresis_enable),
    .low_rate_adc_channel_a(low_rate_adc_channel_a),
    .low_rate_adc_channel_b(low_rate_adc_channel_b),
    .function_route_select(function_route_select),
    .system_interrupt_controller(system_interrupt_controller), .irq(irq));

  pcim_pad_model i_pcim_pad_model (.ext_level(ext_level), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_in(pad_in));

  // ==========================================================================
  // helpers
  task stop_test;
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request stands until ack is seen at a rising edge; read data is taken there
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dd,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dd;
    wb_sel_i <= s;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("ack_cycles", 32'h2, 32'(n));
  endtask

  task wr(input logic [7:0] a, input logic [31:0] dd);
    wb(1'b1, a, dd, 4'hf);
  endtask

  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, q);
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, v, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) o[8*b +: 8] = v[8*b +: 8];
    end
    return o & PCIM_CTL_WMASK;
  endfunction

  // phase 0 low steady after clear, 1 rising, 2 falling after clear while high
  function automatic logic fires(input logic [2:0] t, input logic [1:0] ph);
    case (ph)
      2'd0: return t == PCIM_EVT_LOW;
      2'd1: return t inside {PCIM_EVT_RISE, PCIM_EVT_BOTH, PCIM_EVT_HIGH, PCIM_EVT_LOW};
      default: return t inside {PCIM_EVT_FALL, PCIM_EVT_BOTH, PCIM_EVT_HIGH, PCIM_EVT_LOW};
    endcase
  endfunction

  task ports(input int i, input logic [31:0] v);
    logic a;
    a = i ? low_rate_adc_channel_b : low_rate_adc_channel_a;
    chk("pin_fields", {18'h0, v[14:12], v[11], v[9:4], v[3:0]}, {18'h0,
      drive_strength_level[i], strong_pullup_enable[i], weak_pulldown_enable[i],
      medium_pullup_enable[i], input_path_enable[i], output_driver_enable[i],
      hysteresis_enable[i], a, function_route_select[i]});
    a = v[6] & ~v[4] & (v[3:0] <= PCIM_ROUTE_MAX);
    chk("oe_n", {31'h0, ~a}, {31'h0, pad_oe_n[i]});
  endtask

  task evt(input logic [2:0] t, input logic en, input logic fw);
    logic [31:0] c;
    c = 32'h81 | ({31'h0, fw} << 25) | ({31'h0, en} << 20) | ({29'h0, t} << 21);
    wr(PCIM_OFS_PIN23_CTL, c);
    repeat (4) @(posedge clk);
    wr(PCIM_OFS_IRQ_STAT, 32'h3);
    rd("pend_steady", PCIM_OFS_IRQ_STAT, {31'h0, en & fires(t, 2'd0)});
    ext_level[0] <= 1'b1;
    repeat (5) @(posedge clk);
    rd("pend_rise", PCIM_OFS_IRQ_STAT, {31'h0, en & fires(t, 2'd1)});
    chk("request", {31'h0, en & fw & fires(t, 2'd1)}, {31'h0, system_interrupt_controller[0]});
    chk("irq", {31'h0, en & fires(t, 2'd1)}, {31'h0, irq});
    wr(PCIM_OFS_IRQ_STAT, 32'h3);
    ext_level[0] <= 1'b0;
    repeat (5) @(posedge clk);
    rd("pend_fall", PCIM_OFS_IRQ_STAT, {31'h0, en & fires(t, 2'd2)});
    $display("test event type %0d en %0d fwd %0d done", t, en, fw);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    #100000;
    errors++;
    $display("mismatch watchdog expected done seen hang");
    stop_test();
  end

  initial begin
    void'($urandom(32'he5de6f96));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("oe_n_reset", 32'h3, {30'h0, pad_oe_n});
    ports(0, PCIM_CTL_RESET);
    ports(1, PCIM_CTL_RESET);
    rd("ctl23_reset", PCIM_OFS_PIN23_CTL, PCIM_CTL_RESET);
    rd("ctl24_reset", PCIM_OFS_PIN24_CTL, PCIM_CTL_RESET);
    rd("unmapped", 8'hf0, 32'h0);
    $display("test reset done");
    wr(PCIM_OFS_IRQ_MASK, 32'h1);
    for (int t = 0; t < 8; t++) evt(3'(t), 1'b1, 1'b1);
    evt(PCIM_EVT_RISE, 1'b0, 1'b1);
    evt(PCIM_EVT_BOTH, 1'b1, 1'b0);
    wr(PCIM_OFS_IRQ_MASK, 32'h0);
    @(negedge clk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(PCIM_OFS_PIN24_CTL, 32'h0000_10c1);
    wr(PCIM_OFS_DOUT, 32'h2);
    repeat (3) @(negedge clk);
    chk("pad_drive", 32'h1, {30'h0, pad_oe_n[1], pad_out[1]});
    rd("din", PCIM_OFS_DIN, 32'h2);
    alt_func_out <= 2'($urandom);
    wr(PCIM_OFS_PIN24_CTL, 32'h0000_1042);
    repeat (3) @(negedge clk);
    chk("alt_out", {31'h0, alt_func_out[1]}, {31'h0, pad_out[1]});
    chk("in_off", 32'h0, {31'h0, pin_in_level[1]});
    wr(PCIM_OFS_PIN24_CTL, 32'h0000_1031);
    repeat (3) @(negedge clk);
    chk("oe_off", 32'h3, {30'h0, pad_oe_n[1], low_rate_adc_channel_b});
    // pin 24 drives its own pad high: high level event, forwarded
    wr(PCIM_OFS_PIN24_CTL, 32'h0270_00c1);
    repeat (6) @(negedge clk);
    chk("request24", 32'h1, {31'h0, system_interrupt_controller[1]});
    $display("test pad path done");
    shadow[0] = 32'h0050_0081;
    shadow[1] = 32'h0270_00c1;
    for (int k = 0; k < 24; k++) begin
      int i;
      logic [3:0] s;
      i = int'($urandom_range(1, 0));
      d = $urandom;
      s = 4'($urandom);
      // corner: all ones into pin 24, reserved bits must not stick
      if (k == 0) begin
        i = 1;
        d = 32'hffff_ffff;
        s = 4'hf;
      end
      if (i == 0) d[4] = 1'b0;
      wb(1'b1, i ? PCIM_OFS_PIN24_CTL : PCIM_OFS_PIN23_CTL, d, s);
      shadow[i] = merge(shadow[i], d, s);
      rd("ctl_rand", i ? PCIM_OFS_PIN24_CTL : PCIM_OFS_PIN23_CTL, shadow[i]);
      ports(i, shadow[i]);
    end
    $display("test random control done");
    stop_test();
  end
endmodule
